// ===== bench/du_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side line model: a cable that crosses channel A transmit to channel B
// receive and back. Both lines idle high because the opposite transmitter
// idles high in standard mode, so no floating level can be read as a start bit.
module du_line_model (
    input  wire logic aTx,
    input  wire logic bTx,
    output logic      aRx,
    output logic      bRx
);
    // Straight wires; the receive side sees exactly what the other end sends.
    assign aRx = bTx;
    assign bRx = aTx;
endmodule
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import du_pkg::*;
    typedef struct packed {
        logic [7:0] mcr;
        logic       aux;
        logic       oe;
        logic       rts;
        logic       dtr;
        logic       tx;
    } du_row_type;
    logic       clk, resetn, regWe, regRe, busStyleSel, irq;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata, rd;
    logic       chanAInterruptOut, chanAInterruptOe, chanBInterruptOut, chanBInterruptOe;
    logic       chanAAuxPort_n, chanBAuxPort_n, chanATxReady_n, chanARxReady_n, chanBTxReady_n, chanBRxReady_n;
    logic       chanASerialOut, chanASerialIn, chanARequestToSend_n, chanAClearToSend_n, chanATerminalReady_n;
    logic       chanASetReady_n, chanACarrierDetect_n, chanARingIndicator_n;
    logic       chanBSerialOut, chanBSerialIn, chanBRequestToSend_n, chanBClearToSend_n, chanBTerminalReady_n;
    logic       chanBSetReady_n, chanBCarrierDetect_n, chanBRingIndicator_n;
    int         num_errors = 0;
    int         n_tests = 0;
    // Each row: modem control value and the pin levels it should give on channel A.
    du_row_type rows [6] = '{'{8'h00, 1, 0, 1, 1, 1}, '{8'h01, 1, 0, 1, 0, 1}, '{8'h02, 1, 0, 0, 1, 1},
                            '{8'h08, 0, 1, 1, 1, 1}, '{8'h40, 1, 0, 1, 1, 0}, '{8'h4b, 0, 1, 0, 0, 0}};

    du_uart_pins #(.TICK_DIV(2)) dut (.clk, .resetn, .regAddr, .regWdata, .regWe, .regRe, .regRdata, .irq,
        .busStyleSel, .chanAInterruptOut, .chanAInterruptOe, .chanBInterruptOut, .chanBInterruptOe,
        .chanAAuxPort_n, .chanBAuxPort_n, .chanATxReady_n, .chanARxReady_n, .chanBTxReady_n, .chanBRxReady_n,
        .chanASerialOut, .chanASerialIn, .chanARequestToSend_n, .chanAClearToSend_n, .chanATerminalReady_n,
        .chanASetReady_n, .chanACarrierDetect_n, .chanARingIndicator_n, .chanBSerialOut, .chanBSerialIn,
        .chanBRequestToSend_n, .chanBClearToSend_n, .chanBTerminalReady_n, .chanBSetReady_n,
        .chanBCarrierDetect_n, .chanBRingIndicator_n);
    du_line_model line (.aTx(chanASerialOut), .bTx(chanBSerialOut), .aRx(chanASerialIn), .bRx(chanBSerialIn));

    // Free-running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic complete_run();
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle write strobe; returns just after the edge that takes it.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regWe <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWe <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        regRe <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRe <= 1'b0;
        #1 rd = regRdata;
    endtask

    task automatic do_reset();
        resetn <= 1'b0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
    endtask

    // Bounded wait for a low level: receive ready of either channel, or start bit on A.
    task automatic wait_low(input bit selB);
        int i;
        for (i = 0; i < 2000; i++) begin
            @(posedge clk);
            #1;
            if ((selB ? (chanARxReady_n && chanBRxReady_n) : chanASerialOut) === 1'b0) return;
        end
        num_errors++;
        $display("[ERR] wait expected 0 seen 1");
        complete_run();
    endtask

    initial begin
        resetn = 1'b0; regWe = 1'b0; regRe = 1'b0; regAddr = 4'h0; regWdata = 8'h00; busStyleSel = 1'b1;
        {chanAClearToSend_n, chanASetReady_n, chanACarrierDetect_n, chanARingIndicator_n} = 4'hf;
        {chanBClearToSend_n, chanBSetReady_n, chanBCarrierDetect_n, chanBRingIndicator_n} = 4'hf;
        do_reset();
        chk("txA idle", chanASerialOut, 1);
        chk("txReadyA", chanATxReady_n, 0);
        chk("rxReadyB", chanBRxReady_n, 1);
        chk("auxA", chanAAuxPort_n, 1);
        chk("intOeA", chanAInterruptOe, 0);
        chk("txReadyB", chanBTxReady_n, 0);
        chk("auxB dtrB", {chanBAuxPort_n, chanBTerminalReady_n}, 2'h3);
        chk("rtsB txB", {chanBRequestToSend_n, chanBSerialOut}, 2'h3);
        // Modem control table on channel A.
        foreach (rows[i]) begin
            wr(4'h1, rows[i].mcr);
            repeat (2) @(posedge clk);
            #1;
            chk("auxA", chanAAuxPort_n, rows[i].aux);
            chk("intOeA", chanAInterruptOe, rows[i].oe);
            chk("chan_a_request_to_send_n", chanARequestToSend_n, rows[i].rts);
            chk("chan_a_terminal_ready_n", chanATerminalReady_n, rows[i].dtr);
            chk("txA", chanASerialOut, rows[i].tx);
        end
        // Infrared at both ends; the long wait lets both receivers drop what the mode change started.
        wr(4'h9, 8'h40);
        repeat (400) @(posedge clk);
        rd_reg(4'h0);
        rd_reg(4'h8);
        wr(4'h0, 8'h96);
        wait_low(1'b1);
        rd_reg(4'h8);
        chk("dataB ir", rd, 8'h96);
        // A byte crosses from A to B and raises B's unmasked interrupt.
        do_reset();
        wr(4'h9, 8'h08);
        wr(4'he, 8'h02);
        wr(4'h2, 8'h08);
        wr(4'h0, 8'ha5);
        chk("txReadyA full", chanATxReady_n, 1);
        chk("chan_a_request_to_send_n dir", chanARequestToSend_n, 0);
        wait_low(1'b1);
        chk("irq", irq, 1);
        chk("chan_b_interrupt_out", {chanBInterruptOut, chanBInterruptOe}, 2'b11);
        chk("auxB", chanBAuxPort_n, 0);
        rd_reg(4'h8);
        chk("dataB", rd, 8'ha5);
        chk("rxReadyB", chanBRxReady_n, 1);
        rd_reg(4'hd);
        chk("statusB", rd, 8'h02);
        wr(4'he, 8'h00);
        chk("irq masked", irq, 0);
        wr(4'hd, 8'h02);
        wr(4'he, 8'h02);
        chk("irq cleared", irq, 0);
        rd_reg(4'h7);
        chk("unmapped", rd, 8'h00);
        // General-purpose modem inputs show in status and change nothing else.
        {chanASetReady_n, chanACarrierDetect_n, chanARingIndicator_n} <= 3'h0;
        repeat (6) @(posedge clk);
        rd_reg(4'h4);
        chk("msrA", rd, 8'he0);
        chk("irq", irq, 0);
        chanAClearToSend_n <= 1'b0;
        repeat (6) @(posedge clk);
        rd_reg(4'h4);
        chk("msrA cts", rd, 8'hf0);
        chk("chan_a_request_to_send_n idle", chanARequestToSend_n, 1);
        // Byte from B to A; the drive bit goes up before automatic request-to-send is enabled.
        wr(4'h2, 8'h00);
        wr(4'h1, 8'h02);
        wr(4'h3, 8'h40);
        wr(4'h8, 8'h5a);
        chk("chan_a_request_to_send_n flow", chanARequestToSend_n, 0);
        chk("txReadyB full", chanBTxReady_n, 1);
        wait_low(1'b1);
        chk("chan_a_request_to_send_n rxA full", {chanARequestToSend_n, chanARxReady_n}, 2'b10);
        rd_reg(4'h0);
        chk("dataA", rd, 8'h5a);
        chk("chan_a_request_to_send_n rxA empty", {chanARequestToSend_n, chanARxReady_n}, 2'b01);
        // Automatic clear-to-send holds the byte until the pin goes active.
        chanAClearToSend_n <= 1'b1;
        wr(4'h3, 8'h80);
        wr(4'h0, 8'h3c);
        repeat (100) @(posedge clk);
        #1;
        chk("txA held", {chanASerialOut, chanATxReady_n}, 2'b11);
        chanAClearToSend_n <= 1'b0;
        wait_low(1'b0);
        // Second bus style: B pin held low and driven, A becomes device interrupt.
        busStyleSel <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk("chan_b_interrupt_out style2", {chanBInterruptOut, chanBInterruptOe}, 2'b01);
        chk("chan_a_interrupt_out style2", {chanAInterruptOut, chanAInterruptOe}, 2'b00);
        wr(4'h6, 8'h01);
        chk("chan_a_interrupt_out irq", {chanAInterruptOut, chanAInterruptOe}, 2'b01);
        complete_run();
    end
endmodule
`default_nettype wire

// ===== rtl/du_pkg.sv
// Overview of operation
// - Gate bit drives interrupt pin in first bus style only, auxiliary port low.
// - Second bus style holds channel B interrupt low.
// - Active-low transmit ready shows holding register state.
// - Active-low receive ready shows holding register state.
// - Standard mode: transmit line high when idle.
// - Infrared mode: transmit line rests low.
// - Infrared receive polarity inversion before decoder.
// - Request-to-send doubles as half-duplex direction control.
// - Clear-to-send gates transmit; state visible in status.
// - Set-ready, carrier, ring inputs never affect operation.
// - Terminal-ready output, usable as general output.
// - Bus-select high first style, low second.
// - Second style: channel A open-drain device interrupt.
package du_pkg;

    // Register indices within a channel; address bit 3 selects the channel.
    localparam logic [2:0] DU_REG_DATA        = 3'h0;
    localparam logic [2:0] DU_REG_MODEM_CTRL  = 3'h1;
    localparam logic [2:0] DU_REG_FEATURE     = 3'h2;
    localparam logic [2:0] DU_REG_FLOW        = 3'h3;
    localparam logic [2:0] DU_REG_MODEM_STAT  = 3'h4;
    localparam logic [2:0] DU_REG_INT_STATUS  = 3'h5;
    localparam logic [2:0] DU_REG_INT_MASK    = 3'h6;
    localparam int unsigned DU_CHAN_ADDR_BIT  = 3;

    // Field positions.
    localparam int unsigned DU_MCR_TERMINAL_READY = 0;
    localparam int unsigned DU_MCR_REQUEST_SEND   = 1;
    localparam int unsigned DU_MCR_IRQ_GATE       = 3;
    localparam int unsigned DU_MCR_INFRARED       = 6;
    localparam int unsigned DU_FCTR_IR_INVERT     = 2;
    localparam int unsigned DU_FCTR_HALF_DUPLEX   = 3;
    localparam int unsigned DU_EFR_AUTO_REQUEST   = 6;
    localparam int unsigned DU_EFR_AUTO_CLEAR     = 7;
    localparam int unsigned DU_MSR_CLEAR_TO_SEND  = 4;
    localparam int unsigned DU_MSR_SET_READY      = 5;
    localparam int unsigned DU_MSR_RING           = 6;
    localparam int unsigned DU_MSR_CARRIER        = 7;
    localparam int unsigned DU_INT_TX_EMPTY       = 0;
    localparam int unsigned DU_INT_RX_FULL        = 1;
    localparam int unsigned DU_INT_CTS_CHANGE     = 2;

    // Synchronised pin inputs of one channel.
    localparam int unsigned DU_IN_RX     = 0;
    localparam int unsigned DU_IN_CTS    = 1;
    localparam int unsigned DU_IN_DSR    = 2;
    localparam int unsigned DU_IN_CD     = 3;
    localparam int unsigned DU_IN_RI     = 4;
    localparam int unsigned DU_SYNC_INS  = 5;

    // Timing: clock, line rate, oversampling and frame shape.
    localparam int unsigned DU_CLK_HZ           = 200_000_000;
    localparam int unsigned DU_BAUD_DEFAULT     = 115_200;
    localparam int unsigned DU_OVERSAMPLE       = 16;
    localparam int unsigned DU_TICK_DIV_DEFAULT = DU_CLK_HZ / (DU_BAUD_DEFAULT * DU_OVERSAMPLE);
    localparam logic [3:0]  DU_LAST_TICK        = 4'hf;
    localparam logic [3:0]  DU_MID_TICK         = 4'h7;
    localparam logic [3:0]  DU_IR_PULSE_TICKS   = 4'h3;
    localparam logic [4:0]  DU_IR_STRETCH       = 5'h10;
    localparam logic [3:0]  DU_STOP_BIT         = 4'h9;
    localparam logic [7:0]  DU_REG_RESET        = 8'h00;

    typedef struct packed {
        logic [7:0]                   mcr;
        logic [7:0]                   fctr;
        logic [7:0]                   efr;
        logic [7:0]                   isr;
        logic [7:0]                   imr;
        logic [7:0]                   transmit_holding_reg;
        logic                         thrFull;
        logic [7:0]                   receive_holding_reg;
        logic                         rhrFull;
        logic [9:0]                   txShift;
        logic [3:0]                   txBit;
        logic [3:0]                   txTick;
        logic                         txBusy;
        logic [7:0]                   rxShift;
        logic [3:0]                   rxBit;
        logic [3:0]                   rxTick;
        logic                         rxBusy;
        logic [4:0]                   irStretch;
        logic                         serialOut;
        logic [DU_SYNC_INS-1:0][2:0]  sync;
        logic [DU_SYNC_INS-1:0]       filt;
    } du_chan_type;

    typedef struct packed {
        du_chan_type [1:0] chan;
        logic [15:0]       tickCnt;
        logic [2:0]        busSync;
        logic              busStyle;
        logic [7:0]        rdata;
    } du_state_type;

    // Pins idle high, so synchronisers and filtered levels start high.
    localparam du_chan_type DU_CHAN_RESET = '{sync: '1, filt: '1, serialOut: 1'b1, default: '0};
    localparam du_state_type DU_STATE_RESET = '{chan: {DU_CHAN_RESET, DU_CHAN_RESET},
                                                busSync: 3'h7, busStyle: 1'b1, default: '0};

endpackage

// ===== rtl/du_uart_pins.sv
`timescale 1ns/1ps
`default_nettype none
module du_uart_pins
    import du_pkg::*;
#(
    parameter int unsigned TICK_DIV = DU_TICK_DIV_DEFAULT
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWe,
    input  wire logic       regRe,
    output logic      [7:0] regRdata,
    output logic            irq,
    input  wire logic       busStyleSel,
    output logic            chanAInterruptOut,
    output logic            chanAInterruptOe,
    output logic            chanBInterruptOut,
    output logic            chanBInterruptOe,
    output logic            chanAAuxPort_n,
    output logic            chanBAuxPort_n,
    output logic            chanATxReady_n,
    output logic            chanARxReady_n,
    output logic            chanBTxReady_n,
    output logic            chanBRxReady_n,
    output logic            chanASerialOut,
    input  wire logic       chanASerialIn,
    output logic            chanARequestToSend_n,
    input  wire logic       chanAClearToSend_n,
    output logic            chanATerminalReady_n,
    input  wire logic       chanASetReady_n,
    input  wire logic       chanACarrierDetect_n,
    input  wire logic       chanARingIndicator_n,
    output logic            chanBSerialOut,
    input  wire logic       chanBSerialIn,
    output logic            chanBRequestToSend_n,
    input  wire logic       chanBClearToSend_n,
    output logic            chanBTerminalReady_n,
    input  wire logic       chanBSetReady_n,
    input  wire logic       chanBCarrierDetect_n,
    input  wire logic       chanBRingIndicator_n
);

    du_state_type                         st_q;
    du_state_type                         st_d;
    logic [1:0][DU_SYNC_INS-1:0]          pinIn;
    logic [1:0]                           chanIrq;
    logic                                 tickEn;

    // Gather the pins of each channel so both channels share one description.
    assign pinIn[0] = {chanARingIndicator_n, chanACarrierDetect_n, chanASetReady_n,
                       chanAClearToSend_n, chanASerialIn};
    assign pinIn[1] = {chanBRingIndicator_n, chanBCarrierDetect_n, chanBSetReady_n,
                       chanBClearToSend_n, chanBSerialIn};
    assign tickEn = (st_q.tickCnt == 16'(TICK_DIV - 1));

    // Next-state logic for the divider, the bus-style strap and both channels.
    always_comb begin
        du_chan_type c;
        du_chan_type n;
        logic        hit;
        logic        pulse;
        logic        rxLine;
        logic        ctsActive;
        logic [7:0]  ev;
        logic [7:0]  clr;
        logic [7:0]  rd;
        c         = DU_CHAN_RESET;
        n         = DU_CHAN_RESET;
        hit       = 1'b0;
        pulse     = 1'b0;
        rxLine    = 1'b1;
        ctsActive = 1'b0;
        ev        = 8'h00;
        clr       = 8'h00;
        rd        = 8'h00;
        st_d      = st_q;
        st_d.rdata = 8'h00;
        st_d.tickCnt = tickEn ? 16'h0000 : st_q.tickCnt + 16'h0001;
        // The strap pin is sampled continuously; a level counts once stages two and three agree.
        st_d.busSync = {st_q.busSync[1:0], busStyleSel};
        if (st_q.busSync[1] == st_q.busSync[2]) begin
            st_d.busStyle = st_q.busSync[2];
        end
        for (int ch = 0; ch < 2; ch++) begin
            c   = st_q.chan[ch];
            n   = c;
            ev  = 8'h00;
            hit = (regAddr[DU_CHAN_ADDR_BIT] == 1'(ch));
            for (int i = 0; i < DU_SYNC_INS; i++) begin
                n.sync[i] = {c.sync[i][1:0], pinIn[ch][i]};
                if (c.sync[i][1] == c.sync[i][2]) begin
                    n.filt[i] = c.sync[i][2];
                end
            end
            ctsActive = ~c.filt[DU_IN_CTS];
            if (n.filt[DU_IN_CTS] != c.filt[DU_IN_CTS]) begin
                ev[DU_INT_CTS_CHANGE] = 1'b1;
            end
            // Infrared receive: optional inversion, then a pulse stretched to one bit time.
            pulse = c.filt[DU_IN_RX] ^ c.fctr[DU_FCTR_IR_INVERT];
            if (pulse) begin
                n.irStretch = DU_IR_STRETCH;
            end else if (tickEn && c.irStretch != 5'h00) begin
                n.irStretch = c.irStretch - 5'h01;
            end
            rxLine = c.mcr[DU_MCR_INFRARED] ? ~(pulse | (c.irStretch != 5'h00)) : c.filt[DU_IN_RX];
            // Transmitter: start only when clear-to-send allows it under auto flow.
            if (!c.txBusy && c.thrFull && (!c.efr[DU_EFR_AUTO_CLEAR] || ctsActive)) begin
                n.txBusy  = 1'b1;
                n.txShift = {1'b1, c.transmit_holding_reg, 1'b0};
                n.txBit   = 4'h0;
                n.txTick  = 4'h0;
                n.thrFull = 1'b0;
                ev[DU_INT_TX_EMPTY] = 1'b1;
            end else if (c.txBusy && tickEn) begin
                n.txTick = c.txTick + 4'h1;
                if (c.txTick == DU_LAST_TICK) begin
                    n.txShift = {1'b1, c.txShift[9:1]};
                    n.txBit   = c.txBit + 4'h1;
                    n.txBusy  = (c.txBit != DU_STOP_BIT);
                end
            end
            // A full holding register refuses further writes.
            if (regWe && hit && regAddr[2:0] == DU_REG_DATA && !c.thrFull) begin
                n.transmit_holding_reg     = regWdata;
                n.thrFull = 1'b1;
            end
            // Reading data empties the receive holding register; a byte stored now wins.
            if (regRe && hit && regAddr[2:0] == DU_REG_DATA) begin
                n.rhrFull = 1'b0;
            end
            // Receiver: sixteen ticks per bit, sampled in the middle of each bit.
            if (tickEn) begin
                if (!c.rxBusy) begin
                    if (!rxLine) begin
                        n.rxBusy = 1'b1;
                        n.rxTick = 4'h0;
                        n.rxBit  = 4'h0;
                    end
                end else begin
                    n.rxTick = c.rxTick + 4'h1;
                    if (c.rxTick == DU_MID_TICK) begin
                        n.rxBit = c.rxBit + 4'h1;
                        if (c.rxBit == 4'h0) begin
                            n.rxBusy = ~rxLine;
                        end else if (c.rxBit != DU_STOP_BIT) begin
                            n.rxShift = {rxLine, c.rxShift[7:1]};
                        end else begin
                            n.rxBusy = 1'b0;
                            if (rxLine) begin
                                n.receive_holding_reg     = c.rxShift;
                                n.rhrFull = 1'b1;
                                ev[DU_INT_RX_FULL] = 1'b1;
                            end
                        end
                    end
                end
            end
            // Control register writes.
            if (regWe && hit) begin
                unique case (regAddr[2:0])
                    DU_REG_MODEM_CTRL: n.mcr  = regWdata;
                    DU_REG_FEATURE:    n.fctr = regWdata;
                    DU_REG_FLOW:       n.efr  = regWdata;
                    DU_REG_INT_MASK:   n.imr  = regWdata;
                    default:           n.mcr  = c.mcr;
                endcase
            end
            // Sticky status: writing a one clears, but an event in the same cycle wins.
            clr   = (regWe && hit && regAddr[2:0] == DU_REG_INT_STATUS) ? regWdata : 8'h00;
            n.isr = (c.isr & ~clr) | ev;
            // Standard mode shows the frame bit; infrared sends a short high pulse per zero bit.
            if (n.mcr[DU_MCR_INFRARED]) begin
                n.serialOut = n.txBusy && !n.txShift[0] && (n.txTick < DU_IR_PULSE_TICKS);
            end else begin
                n.serialOut = !n.txBusy || n.txShift[0];
            end
            // Read multiplexer; the set-ready, carrier and ring inputs are only reported, never acted on.
            rd = 8'h00;
            unique case (regAddr[2:0])
                DU_REG_DATA:       rd = c.receive_holding_reg;
                DU_REG_MODEM_CTRL: rd = c.mcr;
                DU_REG_FEATURE:    rd = c.fctr;
                DU_REG_FLOW:       rd = c.efr;
                DU_REG_MODEM_STAT: begin
                    rd[DU_MSR_CLEAR_TO_SEND] = ctsActive;
                    rd[DU_MSR_SET_READY]     = ~c.filt[DU_IN_DSR];
                    rd[DU_MSR_RING]          = ~c.filt[DU_IN_RI];
                    rd[DU_MSR_CARRIER]       = ~c.filt[DU_IN_CD];
                end
                DU_REG_INT_STATUS: rd = c.isr;
                DU_REG_INT_MASK:   rd = c.imr;
                default:           rd = 8'h00;
            endcase
            if (regRe && hit) begin
                st_d.rdata = rd;
            end
            st_d.chan[ch] = n;
        end
    end

    // Single state register with a synchronous reset.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q <= DU_STATE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // A channel requests service while any unmasked status bit is set.
    assign chanIrq[0] = |(st_q.chan[0].isr & st_q.chan[0].imr);
    assign chanIrq[1] = |(st_q.chan[1].isr & st_q.chan[1].imr);
    assign irq        = |chanIrq;
    assign regRdata   = st_q.rdata;

    // First style: gated active drivers. Second style: A is open-drain device interrupt, B held low.
    assign chanAInterruptOut = st_q.busStyle ? chanIrq[0] : 1'b0;
    assign chanAInterruptOe  = st_q.busStyle ? st_q.chan[0].mcr[DU_MCR_IRQ_GATE] : irq;
    assign chanBInterruptOut = st_q.busStyle ? chanIrq[1] : 1'b0;
    assign chanBInterruptOe  = st_q.busStyle ? st_q.chan[1].mcr[DU_MCR_IRQ_GATE] : 1'b1;
    assign chanAAuxPort_n    = ~st_q.chan[0].mcr[DU_MCR_IRQ_GATE];
    assign chanBAuxPort_n    = ~st_q.chan[1].mcr[DU_MCR_IRQ_GATE];

    // Ready outputs are low while the holding register can take or has a byte.
    assign chanATxReady_n = st_q.chan[0].thrFull;
    assign chanBTxReady_n = st_q.chan[1].thrFull;
    assign chanARxReady_n = ~st_q.chan[0].rhrFull;
    assign chanBRxReady_n = ~st_q.chan[1].rhrFull;
    assign chanASerialOut = st_q.chan[0].serialOut;
    assign chanBSerialOut = st_q.chan[1].serialOut;

    // Request-to-send: direction control wins, then auto flow, then the plain drive bit.
    // Auto flow only ever withdraws the drive bit, so software must set that bit first.
    function automatic logic rtsLevel(input du_chan_type c);
        if (c.fctr[DU_FCTR_HALF_DUPLEX]) begin
            return ~(c.txBusy | c.thrFull);
        end
        return ~(c.mcr[DU_MCR_REQUEST_SEND] & ~(c.efr[DU_EFR_AUTO_REQUEST] & c.rhrFull));
    endfunction
    assign chanARequestToSend_n = rtsLevel(st_q.chan[0]);
    assign chanBRequestToSend_n = rtsLevel(st_q.chan[1]);
    assign chanATerminalReady_n = ~st_q.chan[0].mcr[DU_MCR_TERMINAL_READY];
    assign chanBTerminalReady_n = ~st_q.chan[1].mcr[DU_MCR_TERMINAL_READY];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Checks are written against channel A, except chan_b_low_a on channel B's pin; channel B shares the same logic.
    logic writeA;
    assign writeA = regWe && !regAddr[DU_CHAN_ADDR_BIT];

    gate_on_a: assert property (writeA && regAddr[2:0] == DU_REG_MODEM_CTRL && regWdata[DU_MCR_IRQ_GATE]
        && st_q.busStyle && st_d.busStyle |=> chanAInterruptOe && !chanAAuxPort_n)
        else $error("gate bit set but interrupt pin not driven");
    gate_off_a: assert property (writeA && regAddr[2:0] == DU_REG_MODEM_CTRL && !regWdata[DU_MCR_IRQ_GATE]
        && st_q.busStyle && st_d.busStyle |=> !chanAInterruptOe && chanAAuxPort_n)
        else $error("gate bit clear but interrupt pin driven");
    chan_b_low_a: assert property (!st_q.busStyle |-> chanBInterruptOe && !chanBInterruptOut)
        else $error("channel B interrupt not held low");
    tx_ready_a: assert property (writeA && regAddr[2:0] == DU_REG_DATA && !chanATxReady_n
        |=> chanATxReady_n ##1 (chanATxReady_n || st_q.chan[0].txBusy))
        else $error("transmit ready not tracking holding register");
    rx_ready_a: assert property ($fell(chanARxReady_n) |-> st_q.chan[0].isr[DU_INT_RX_FULL])
        else $error("receive ready fell without a stored byte");
    std_idle_a: assert property (!st_q.chan[0].txBusy && !st_q.chan[0].mcr[DU_MCR_INFRARED]
        |-> chanASerialOut)
        else $error("standard transmit line not high while idle");
    ir_idle_a: assert property (!st_q.chan[0].txBusy && st_q.chan[0].mcr[DU_MCR_INFRARED]
        |-> !chanASerialOut)
        else $error("infrared transmit line not low while idle");
    cts_gate_a: assert property (st_q.chan[0].efr[DU_EFR_AUTO_CLEAR] && st_q.chan[0].filt[DU_IN_CTS]
        && !st_q.chan[0].txBusy |=> !st_q.chan[0].txBusy)
        else $error("transmit started while clear-to-send inactive");
    cts_status_a: assert property (regRe && !regAddr[DU_CHAN_ADDR_BIT] && regAddr[2:0] == DU_REG_MODEM_STAT
        |=> regRdata[DU_MSR_CLEAR_TO_SEND] == !$past(st_q.chan[0].filt[DU_IN_CTS]))
        else $error("clear-to-send status bit wrong");
    dir_ctrl_a: assert property (st_q.chan[0].fctr[DU_FCTR_HALF_DUPLEX] && st_q.chan[0].txBusy
        |-> !chanARequestToSend_n)
        else $error("direction control not asserted during transmit");
    dtr_out_a: assert property (writeA && regAddr[2:0] == DU_REG_MODEM_CTRL
        |=> chanATerminalReady_n == !$past(regWdata[DU_MCR_TERMINAL_READY]))
        else $error("terminal ready does not follow its bit");
    irq_pend_a: assert property (writeA && regAddr[2:0] == DU_REG_INT_MASK && (regWdata & st_q.chan[0].isr) != 8'h00
        |=> irq)
        else $error("enabled condition did not raise interrupt");

    frame_done_c: cover property ($fell(st_q.chan[0].txBusy));
    byte_rcvd_c: cover property ($fell(chanARxReady_n));
    dev_irq_c: cover property (!st_q.busStyle && chanAInterruptOe);
    ir_frame_c: cover property (st_q.chan[0].mcr[DU_MCR_INFRARED] && $rose(chanASerialOut));

endmodule
`default_nettype wire
